// file: mpg_pkg.sv
package mpg_pkg;

    // register geometry
    localparam int REG_W      = 8;
    localparam int APB_DATA_W = 32;
    localparam int APB_ADDR_W = 8;
    localparam int APB_STRB_W = 4;

    // port widths
    localparam int P0_W  = 2;
    localparam int P1_W  = 8;
    localparam int P3_W  = 4;
    localparam int P6_W  = 2;
    localparam int P12_W = 3;

    // byte addresses of the register words
    localparam logic [APB_ADDR_W-1:0] ADDR_DIR0      = 8'h00;
    localparam logic [APB_ADDR_W-1:0] ADDR_DIR1      = 8'h04;
    localparam logic [APB_ADDR_W-1:0] ADDR_DIR3      = 8'h08;
    localparam logic [APB_ADDR_W-1:0] ADDR_DIR6      = 8'h0C;
    localparam logic [APB_ADDR_W-1:0] ADDR_DIR12     = 8'h10;
    localparam logic [APB_ADDR_W-1:0] ADDR_LATCH0    = 8'h20;
    localparam logic [APB_ADDR_W-1:0] ADDR_LATCH1    = 8'h24;
    localparam logic [APB_ADDR_W-1:0] ADDR_LATCH3    = 8'h28;
    localparam logic [APB_ADDR_W-1:0] ADDR_LATCH6    = 8'h2C;
    localparam logic [APB_ADDR_W-1:0] ADDR_LATCH12   = 8'h30;
    localparam logic [APB_ADDR_W-1:0] ADDR_PULL0     = 8'h40;
    localparam logic [APB_ADDR_W-1:0] ADDR_PULL1     = 8'h44;
    localparam logic [APB_ADDR_W-1:0] ADDR_PULL3     = 8'h48;
    localparam logic [APB_ADDR_W-1:0] ADDR_PULL12    = 8'h4C;
    localparam logic [APB_ADDR_W-1:0] ADDR_CLKMODE   = 8'h60;
    localparam logic [APB_ADDR_W-1:0] ADDR_SERMODE   = 8'h64;
    localparam logic [APB_ADDR_W-1:0] ADDR_SERCLK    = 8'h68;
    localparam logic [APB_ADDR_W-1:0] ADDR_STATUS    = 8'h6C;

    // reset values
    localparam logic [REG_W-1:0] DIR_RESET    = 8'hFF;
    localparam logic [REG_W-1:0] LATCH_RESET  = 8'h00;
    localparam logic [REG_W-1:0] PULL_RESET   = 8'h00;
    localparam logic [REG_W-1:0] CONFIG_RESET = 8'h00;

    // port twelve: pull-up only on bit zero, bits one and two go to the clock
    localparam logic [P12_W-1:0] P12_PULL_MASK  = 3'h1;
    localparam logic [P12_W-1:0] P12_CLOCK_PINS = 3'h6;

    // status word fields
    localparam int STAT_CLOCK_BIT  = 0;
    localparam int STAT_SERIAL_BIT = 1;

    localparam logic [APB_DATA_W-REG_W-1:0] RDATA_PAD = 24'h000000;

    typedef enum logic [4:0] {
        SEL_NONE, SEL_DIR0, SEL_DIR1, SEL_DIR3, SEL_DIR6, SEL_DIR12,
        SEL_LATCH0, SEL_LATCH1, SEL_LATCH3, SEL_LATCH6, SEL_LATCH12,
        SEL_PULL0, SEL_PULL1, SEL_PULL3, SEL_PULL12,
        SEL_CLKMODE, SEL_SERMODE, SEL_SERCLK, SEL_STATUS
    } mpg_sel_t;

endpackage : mpg_pkg

// file: mpg_port_if.sv
`timescale 1ns/10ps
interface mpg_port_if #(
    parameter int W = 8
);
    logic [W-1:0] dir;
    logic [W-1:0] latch;
    logic [W-1:0] pullSel;
    logic [W-1:0] release_;
    logic [W-1:0] pinIn;
    logic [W-1:0] nextOut;
    logic [W-1:0] nextOe;
    logic [W-1:0] nextPull;
    logic [W-1:0] readVal;

    modport ctl   (output dir, latch, pullSel, release_, pinIn,
                   input  nextOut, nextOe, nextPull, readVal);
    modport slice (input  dir, latch, pullSel, release_, pinIn,
                   output nextOut, nextOe, nextPull, readVal);
endinterface : mpg_port_if

// file: mpg_port_slice.sv
`timescale 1ns/10ps
module mpg_port_slice #(
    parameter int           W          = 8,
    parameter bit           OPEN_DRAIN = 1'b0,
    parameter logic [W-1:0] PULL_MASK  = '1
) (
    // port bundle
    mpg_port_if.slice bus
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic isOut;
            // direction bit one means input
            assign isOut = ~bus.dir[i] & ~bus.release_[i];
            // open drain only sinks: enable while a zero is latched
            assign bus.nextOe[i]   = OPEN_DRAIN ? (isOut & ~bus.latch[i]) : isOut;
            assign bus.nextOut[i]  = OPEN_DRAIN ? 1'b0 : bus.latch[i];
            // pull-up never fights the own driver
            assign bus.nextPull[i] = PULL_MASK[i] & bus.pullSel[i] & ~isOut;
            assign bus.readVal[i]  = isOut ? bus.latch[i] : bus.pinIn[i];
        end
    endgenerate

endmodule : mpg_port_slice

// file: mpg_gpio_top.sv
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - nineteen pins: seventeen push-pull, two open-drain.
// - port zero has two bits, own latches, per-bit direction.
// - port zero pull-up acts only on an input bit with its option set.
// - reset puts every bit of every port into input mode.
// - port one has eight bits, per-bit direction and input pull-ups.
// - port three has four bits, per-bit direction and input pull-ups.
// - port six has two bits, no pull-up, open-drain output.
// - port twelve has three bits with latches and per-bit direction.
// - port twelve pull-up exists only on bit zero.
// - clock mode resets to zero; nonzero hands port twelve bits one, two to clock.
// - direction registers reset to all ones; pinless bits stay one.
module mpg_gpio_top
    import mpg_pkg::*;
#(
    parameter int ADDR_W = APB_ADDR_W
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [APB_DATA_W-1:0] pwdata,
    input  wire logic [APB_STRB_W-1:0] pstrb,
    output logic      [APB_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // port zero pins
    input  wire logic [P0_W-1:0]       portZeroIn,
    output logic      [P0_W-1:0]       portZeroOut,
    output logic      [P0_W-1:0]       portZeroOe,
    output logic      [P0_W-1:0]       portZeroPullup,
    // port one pins
    input  wire logic [P1_W-1:0]       portOneIn,
    output logic      [P1_W-1:0]       portOneOut,
    output logic      [P1_W-1:0]       portOneOe,
    output logic      [P1_W-1:0]       portOnePullup,
    // port three pins
    input  wire logic [P3_W-1:0]       portThreeIn,
    output logic      [P3_W-1:0]       portThreeOut,
    output logic      [P3_W-1:0]       portThreeOe,
    output logic      [P3_W-1:0]       portThreePullup,
    // port six pins, open drain
    input  wire logic [P6_W-1:0]       portSixIn,
    output logic      [P6_W-1:0]       portSixOut,
    output logic      [P6_W-1:0]       portSixOe,
    // port twelve pins
    input  wire logic [P12_W-1:0]      portTwelveIn,
    output logic      [P12_W-1:0]      portTwelveOut,
    output logic      [P12_W-1:0]      portTwelveOe,
    output logic      [P12_W-1:0]      portTwelvePullup,
    // status toward clock and serial logic
    output logic                       clockPinsTaken,
    output logic                       serialPortsFree
);

    // register file
    logic [REG_W-1:0] port_zero_direction;
    logic [REG_W-1:0] port_one_direction;
    logic [REG_W-1:0] port_three_direction;
    logic [REG_W-1:0] port_six_direction;
    logic [REG_W-1:0] port_twelve_direction;
    logic [P0_W-1:0]  port_zero_latch;
    logic [P1_W-1:0]  port_one_latch;
    logic [P3_W-1:0]  port_three_latch;
    logic [P6_W-1:0]  port_six_latch;
    logic [P12_W-1:0] port_twelve_latch;
    logic [P0_W-1:0]  port_zero_pullup_select;
    logic [P1_W-1:0]  port_one_pullup_select;
    logic [P3_W-1:0]  port_three_pullup_select;
    logic             port_twelve_pullup_select;
    logic [REG_W-1:0] clock_operation_mode_select;
    logic [REG_W-1:0] serial_mode_config;
    logic [REG_W-1:0] serial_clock_config;

    // bus decode
    mpg_sel_t         setupSel;
    mpg_sel_t         accessSel;
    logic             wrEn;
    logic [REG_W-1:0] wrByte;
    logic [REG_W-1:0] next_rdByte;
    logic             clockOwnsPins;
    logic             serialIdle;

    function automatic mpg_sel_t decodeAddr(input logic [ADDR_W-1:0] a);
        mpg_sel_t s;
        s = SEL_NONE;
        unique case (a)
            ADDR_DIR0:    s = SEL_DIR0;
            ADDR_DIR1:    s = SEL_DIR1;
            ADDR_DIR3:    s = SEL_DIR3;
            ADDR_DIR6:    s = SEL_DIR6;
            ADDR_DIR12:   s = SEL_DIR12;
            ADDR_LATCH0:  s = SEL_LATCH0;
            ADDR_LATCH1:  s = SEL_LATCH1;
            ADDR_LATCH3:  s = SEL_LATCH3;
            ADDR_LATCH6:  s = SEL_LATCH6;
            ADDR_LATCH12: s = SEL_LATCH12;
            ADDR_PULL0:   s = SEL_PULL0;
            ADDR_PULL1:   s = SEL_PULL1;
            ADDR_PULL3:   s = SEL_PULL3;
            ADDR_PULL12:  s = SEL_PULL12;
            ADDR_CLKMODE: s = SEL_CLKMODE;
            ADDR_SERMODE: s = SEL_SERMODE;
            ADDR_SERCLK:  s = SEL_SERCLK;
            ADDR_STATUS:  s = SEL_STATUS;
            default:      s = SEL_NONE;
        endcase
        return s;
    endfunction : decodeAddr

    // pinless direction positions are forced to one
    function automatic logic [REG_W-1:0] dirWrite(input logic [REG_W-1:0] d, input int w);
        logic [REG_W-1:0] mask;
        mask = DIR_RESET >> (REG_W - w);
        return d | ~mask;
    endfunction : dirWrite

    assign setupSel  = decodeAddr(paddr);
    assign accessSel = decodeAddr(paddr);
    // write lands only on the completing access edge
    assign wrEn      = psel & penable & pready & pwrite & pstrb[0];
    assign wrByte    = pwdata[REG_W-1:0];

    assign clockOwnsPins = (clock_operation_mode_select != CONFIG_RESET);
    assign serialIdle    = (serial_mode_config == CONFIG_RESET) &&
                           (serial_clock_config == CONFIG_RESET);

    // per-port pin logic
    mpg_port_if #(.W(P0_W))  p0If();
    mpg_port_if #(.W(P1_W))  p1If();
    mpg_port_if #(.W(P3_W))  p3If();
    mpg_port_if #(.W(P6_W))  p6If();
    mpg_port_if #(.W(P12_W)) p12If();

    assign p0If.dir      = port_zero_direction[P0_W-1:0];
    assign p0If.latch    = port_zero_latch;
    assign p0If.pullSel  = port_zero_pullup_select;
    assign p0If.release_ = '0;
    assign p0If.pinIn    = portZeroIn;

    assign p1If.dir      = port_one_direction[P1_W-1:0];
    assign p1If.latch    = port_one_latch;
    assign p1If.pullSel  = port_one_pullup_select;
    assign p1If.release_ = '0;
    assign p1If.pinIn    = portOneIn;

    assign p3If.dir      = port_three_direction[P3_W-1:0];
    assign p3If.latch    = port_three_latch;
    assign p3If.pullSel  = port_three_pullup_select;
    assign p3If.release_ = '0;
    assign p3If.pinIn    = portThreeIn;

    assign p6If.dir      = port_six_direction[P6_W-1:0];
    assign p6If.latch    = port_six_latch;
    assign p6If.pullSel  = '0;
    assign p6If.release_ = '0;
    assign p6If.pinIn    = portSixIn;

    assign p12If.dir      = port_twelve_direction[P12_W-1:0];
    assign p12If.latch    = port_twelve_latch;
    assign p12If.pullSel  = {{(P12_W-1){1'b0}}, port_twelve_pullup_select};
    assign p12If.release_ = clockOwnsPins ? P12_CLOCK_PINS : '0;
    assign p12If.pinIn    = portTwelveIn;

    mpg_port_slice #(.W(P0_W), .OPEN_DRAIN(1'b0), .PULL_MASK('1)) u_port0 (
        .bus (p0If)
    );
    mpg_port_slice #(.W(P1_W), .OPEN_DRAIN(1'b0), .PULL_MASK('1)) u_port1 (
        .bus (p1If)
    );
    mpg_port_slice #(.W(P3_W), .OPEN_DRAIN(1'b0), .PULL_MASK('1)) u_port3 (
        .bus (p3If)
    );
    mpg_port_slice #(.W(P6_W), .OPEN_DRAIN(1'b1), .PULL_MASK('0)) u_port6 (
        .bus (p6If)
    );
    mpg_port_slice #(.W(P12_W), .OPEN_DRAIN(1'b0), .PULL_MASK(P12_PULL_MASK)) u_port12 (
        .bus (p12If)
    );

    // direction registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_zero_direction   <= DIR_RESET;
            port_one_direction    <= DIR_RESET;
            port_three_direction  <= DIR_RESET;
            port_six_direction    <= DIR_RESET;
            port_twelve_direction <= DIR_RESET;
        end else if (wrEn) begin
            unique case (accessSel)
                SEL_DIR0:  port_zero_direction   <= dirWrite(wrByte, P0_W);
                SEL_DIR1:  port_one_direction    <= dirWrite(wrByte, P1_W);
                SEL_DIR3:  port_three_direction  <= dirWrite(wrByte, P3_W);
                SEL_DIR6:  port_six_direction    <= dirWrite(wrByte, P6_W);
                SEL_DIR12: port_twelve_direction <= dirWrite(wrByte, P12_W);
                default: begin
                end
            endcase
        end
    end

    // output latches
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_zero_latch   <= LATCH_RESET[P0_W-1:0];
            port_one_latch    <= LATCH_RESET[P1_W-1:0];
            port_three_latch  <= LATCH_RESET[P3_W-1:0];
            port_six_latch    <= LATCH_RESET[P6_W-1:0];
            port_twelve_latch <= LATCH_RESET[P12_W-1:0];
        end else if (wrEn) begin
            unique case (accessSel)
                SEL_LATCH0:  port_zero_latch   <= wrByte[P0_W-1:0];
                SEL_LATCH1:  port_one_latch    <= wrByte[P1_W-1:0];
                SEL_LATCH3:  port_three_latch  <= wrByte[P3_W-1:0];
                SEL_LATCH6:  port_six_latch    <= wrByte[P6_W-1:0];
                SEL_LATCH12: port_twelve_latch <= wrByte[P12_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // pull-up option registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_zero_pullup_select   <= PULL_RESET[P0_W-1:0];
            port_one_pullup_select    <= PULL_RESET[P1_W-1:0];
            port_three_pullup_select  <= PULL_RESET[P3_W-1:0];
            port_twelve_pullup_select <= PULL_RESET[0];
        end else if (wrEn) begin
            unique case (accessSel)
                SEL_PULL0:  port_zero_pullup_select   <= wrByte[P0_W-1:0];
                SEL_PULL1:  port_one_pullup_select    <= wrByte[P1_W-1:0];
                SEL_PULL3:  port_three_pullup_select  <= wrByte[P3_W-1:0];
                SEL_PULL12: port_twelve_pullup_select <= wrByte[0];
                default: begin
                end
            endcase
        end
    end

    // clock and serial configuration
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clock_operation_mode_select <= CONFIG_RESET;
            serial_mode_config          <= CONFIG_RESET;
            serial_clock_config         <= CONFIG_RESET;
        end else if (wrEn) begin
            unique case (accessSel)
                SEL_CLKMODE: clock_operation_mode_select <= wrByte;
                SEL_SERMODE: serial_mode_config          <= wrByte;
                SEL_SERCLK:  serial_clock_config         <= wrByte;
                default: begin
                end
            endcase
        end
    end

    // read mux, sampled in the setup cycle
    always_comb begin
        next_rdByte = '0;
        unique case (setupSel)
            SEL_DIR0:    next_rdByte = port_zero_direction;
            SEL_DIR1:    next_rdByte = port_one_direction;
            SEL_DIR3:    next_rdByte = port_three_direction;
            SEL_DIR6:    next_rdByte = port_six_direction;
            SEL_DIR12:   next_rdByte = port_twelve_direction;
            SEL_LATCH0:  next_rdByte = {{(REG_W-P0_W){1'b0}}, p0If.readVal};
            SEL_LATCH1:  next_rdByte = p1If.readVal;
            SEL_LATCH3:  next_rdByte = {{(REG_W-P3_W){1'b0}}, p3If.readVal};
            SEL_LATCH6:  next_rdByte = {{(REG_W-P6_W){1'b0}}, p6If.readVal};
            SEL_LATCH12: next_rdByte = {{(REG_W-P12_W){1'b0}}, p12If.readVal};
            SEL_PULL0:   next_rdByte = {{(REG_W-P0_W){1'b0}}, port_zero_pullup_select};
            SEL_PULL1:   next_rdByte = port_one_pullup_select;
            SEL_PULL3:   next_rdByte = {{(REG_W-P3_W){1'b0}}, port_three_pullup_select};
            SEL_PULL12:  next_rdByte = {{(REG_W-1){1'b0}}, port_twelve_pullup_select};
            SEL_CLKMODE: next_rdByte = clock_operation_mode_select;
            SEL_SERMODE: next_rdByte = serial_mode_config;
            SEL_SERCLK:  next_rdByte = serial_clock_config;
            SEL_STATUS: begin
                next_rdByte[STAT_CLOCK_BIT]  = clockOwnsPins;
                next_rdByte[STAT_SERIAL_BIT] = serialIdle;
            end
            SEL_NONE:    next_rdByte = '0;
        endcase
    end

    // apb answer: always zero wait states
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                pslverr <= (setupSel == SEL_NONE);
                prdata  <= pwrite ? '0 : {RDATA_PAD, next_rdByte};
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // pin drivers, registered so pins never glitch from the decode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            portZeroOut      <= '0;
            portZeroOe       <= '0;
            portZeroPullup   <= '0;
            portOneOut       <= '0;
            portOneOe        <= '0;
            portOnePullup    <= '0;
            portThreeOut     <= '0;
            portThreeOe      <= '0;
            portThreePullup  <= '0;
            portSixOut       <= '0;
            portSixOe        <= '0;
            portTwelveOut    <= '0;
            portTwelveOe     <= '0;
            portTwelvePullup <= '0;
        end else begin
            portZeroOut      <= p0If.nextOut;
            portZeroOe       <= p0If.nextOe;
            portZeroPullup   <= p0If.nextPull;
            portOneOut       <= p1If.nextOut;
            portOneOe        <= p1If.nextOe;
            portOnePullup    <= p1If.nextPull;
            portThreeOut     <= p3If.nextOut;
            portThreeOe      <= p3If.nextOe;
            portThreePullup  <= p3If.nextPull;
            portSixOut       <= p6If.nextOut;
            portSixOe        <= p6If.nextOe;
            portTwelveOut    <= p12If.nextOut;
            portTwelveOe     <= p12If.nextOe;
            portTwelvePullup <= p12If.nextPull;
        end
    end

    // status flags for the clock generator and serial unit
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clockPinsTaken  <= 1'b0;
            serialPortsFree <= 1'b1;
        end else begin
            clockPinsTaken  <= clockOwnsPins;
            serialPortsFree <= serialIdle;
        end
    end

endmodule : mpg_gpio_top

// file: mpg_gpio_monitor.sv
`timescale 1ns/10ps
module mpg_gpio_monitor
    import mpg_pkg::*;
#(
    parameter int ADDR_W = APB_ADDR_W
) (
    // clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_W-1:0]     paddr,
    input wire logic [APB_DATA_W-1:0] pwdata,
    input wire logic [APB_STRB_W-1:0] pstrb,
    input wire logic                  pready,
    // pins
    input wire logic [P0_W-1:0]       portZeroOe,
    input wire logic [P0_W-1:0]       portZeroPullup,
    input wire logic [P1_W-1:0]       portOneOe,
    input wire logic [P1_W-1:0]       portOnePullup,
    input wire logic [P3_W-1:0]       portThreeOe,
    input wire logic [P3_W-1:0]       portThreePullup,
    input wire logic [P6_W-1:0]       portSixOut,
    input wire logic [P6_W-1:0]       portSixOe,
    input wire logic [P12_W-1:0]      portTwelveOe,
    input wire logic [P12_W-1:0]      portTwelvePullup,
    input wire logic                  clockPinsTaken
);
    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    reset_inputs_a: assert property (
        $fell(rst) |-> {portZeroOe, portOneOe, portThreeOe, portSixOe, portTwelveOe} == '0)
        else $error("pin driven right after reset");
    clock_reset_a: assert property (
        $fell(rst) |-> !clockPinsTaken && {portZeroPullup, portTwelvePullup} == '0)
        else $error("clock owns pins after reset");
    dir_zero_a: assert property (
        psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_DIR0
        |=> ##1 portZeroOe == ~$past(pwdata[1:0], 2))
        else $error("port zero enable does not follow direction");
    dir_one_a: assert property (
        psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_DIR1
        |=> ##1 portOneOe == ~$past(pwdata[7:0], 2))
        else $error("port one enable does not follow direction");
    pull_off_a: assert property (
        (portZeroOe & portZeroPullup) == '0 && (portOneOe & portOnePullup) == '0
        && (portThreeOe & portThreePullup) == '0 && (portTwelveOe & portTwelvePullup) == '0)
        else $error("pull-up on a driven pin");
    drain_low_a: assert property (
        portSixOut == 2'h0)
        else $error("open drain pin driven high");
    twelve_pull_a: assert property (
        portTwelvePullup[2:1] == 2'h0)
        else $error("pull-up on port twelve upper bits");
    clock_owns_a: assert property (
        clockPinsTaken && $past(clockPinsTaken) |-> portTwelveOe[2:1] == 2'h0
        && portTwelvePullup[2:1] == 2'h0)
        else $error("clock pins still used as port");
endmodule : mpg_gpio_monitor

bind mpg_gpio_top mpg_gpio_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .portZeroOe, .portZeroPullup, .portOneOe, .portOnePullup, .portThreeOe,
    .portThreePullup, .portSixOut, .portSixOe, .portTwelveOe, .portTwelvePullup,
    .clockPinsTaken
);

// file: mpg_board.sv
`timescale 1ns/10ps
module mpg_board #(
    parameter int W = 8
) (
    // drive from the device
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] pu,
    // level the board puts on a free pin
    input  wire logic [W-1:0] ext,
    // resolved pin
    output logic      [W-1:0] pin
);
    // a released open-drain pin has no keeper, so it shows the board level
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin[i] = oe[i] ? out[i] : (pu[i] ? 1'b1 : ext[i]);
        end
    end
endmodule : mpg_board

// file: mpg_gpio_tb_top.sv
`timescale 1ns/10ps
module mpg_gpio_tb_top
    import mpg_pkg::*;
();
    localparam logic [7:0] MSK [5]  = '{8'h03, 8'hFF, 8'h0F, 8'h03, 8'h07};
    localparam logic [7:0] PMS [5]  = '{8'h03, 8'hFF, 8'h0F, 8'h00, 8'h01};
    localparam logic [7:0] DIRA [5] = '{ADDR_DIR0, ADDR_DIR1, ADDR_DIR3, ADDR_DIR6, ADDR_DIR12};
    localparam logic [7:0] LATA [5] = '{ADDR_LATCH0, ADDR_LATCH1, ADDR_LATCH3, ADDR_LATCH6,
                                        ADDR_LATCH12};
    localparam logic [7:0] PULA [5] = '{ADDR_PULL0, ADDR_PULL1, ADDR_PULL3, 8'h00, ADDR_PULL12};
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, e, clkMode;
    logic        clockPinsTaken, serialPortsFree;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  ext [5], dirS [5], latS [5], pulS [5];
    wire  [7:0]  out [5], oe [5], pu [5], pin [5];
    int          seed = 45764, errors = 0, checks_done = 0, k;

    mpg_gpio_top u_dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portZeroIn(pin[0][1:0]), .portZeroOut(out[0][1:0]),
        .portZeroOe(oe[0][1:0]), .portZeroPullup(pu[0][1:0]), .portOneIn(pin[1]),
        .portOneOut(out[1]), .portOneOe(oe[1]), .portOnePullup(pu[1]),
        .portThreeIn(pin[2][3:0]), .portThreeOut(out[2][3:0]), .portThreeOe(oe[2][3:0]),
        .portThreePullup(pu[2][3:0]), .portSixIn(pin[3][1:0]), .portSixOut(out[3][1:0]),
        .portSixOe(oe[3][1:0]), .portTwelveIn(pin[4][2:0]), .portTwelveOut(out[4][2:0]),
        .portTwelveOe(oe[4][2:0]), .portTwelvePullup(pu[4][2:0]),
        .clockPinsTaken(clockPinsTaken), .serialPortsFree(serialPortsFree));
    for (genvar g = 0; g < 5; g++) begin : g_board
        mpg_board u_brd (.out(out[g]), .oe(oe[g]), .pu(pu[g]), .ext(ext[g]), .pin(pin[g]));
    end
    assign pu[3] = 8'h00;

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            test_done();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'hF);
    endtask : wr

    // clock-owned port twelve bits read as inputs
    function automatic logic [7:0] effDir(input int p);
        return dirS[p] | ((p == 4 && clkMode) ? 8'h06 : 8'h00);
    endfunction : effDir

    function automatic logic [7:0] expRd(input int p, input logic [7:0] d);
        return ((~d & latS[p]) | (d & ((pulS[p] & PMS[p]) | ext[p]))) & MSK[p];
    endfunction : expRd

    task automatic probe(input int p);
        logic [7:0] d;
        d = effDir(p);
        repeat (3) @(posedge ref_clk);
        apb(1'b0, LATA[p], 32'h0, 4'h0);
        chk(r, {24'h0, expRd(p, d)});
        apb(1'b0, DIRA[p], 32'h0, 4'h0);
        chk(r, {24'h0, dirS[p] | ~MSK[p]});
        chk({24'h0, oe[p] & MSK[p]}, {24'h0, (p == 3 ? ~d & ~latS[p] : ~d) & MSK[p]});
        chk({24'h0, out[p] & ~d & MSK[p]}, {24'h0, (p == 3 ? 8'h0 : latS[p]) & ~d & MSK[p]});
        chk({24'h0, pu[p] & MSK[p]}, {24'h0, d & pulS[p] & PMS[p]});
    endtask : probe

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        clkMode = 1'b0;
        for (int i = 0; i < 5; i++) begin
            ext[i] = 8'($random(seed));
            dirS[i] = 8'hFF;
            latS[i] = 8'h0;
            pulS[i] = 8'h0;
        end
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) probe(i);
        apb(1'b0, ADDR_CLKMODE, 32'h0, 4'h0);
        chk(r, 32'h0);
        $display("reset test done");
        // first pass: all outputs, latch ones
        for (int i = 0; i < 60; i++) begin
            k = (i < 5) ? i : int'($unsigned($random(seed)) % 5);
            dirS[k] = (i < 5) ? 8'h00 : 8'($random(seed));
            latS[k] = (i < 5) ? 8'hFF : 8'($random(seed));
            ext[k] <= 8'($random(seed));
            wr(DIRA[k], dirS[k]);
            wr(LATA[k], latS[k]);
            if (k != 3) begin
                pulS[k] = 8'($random(seed));
                wr(PULA[k], pulS[k]);
            end
            probe(k);
        end
        $display("port test done");
        clkMode = 1'b1;
        wr(ADDR_CLKMODE, 8'($random(seed)) | 8'h01);
        dirS[4] = 8'h00;
        wr(DIRA[4], 8'h00);
        probe(4);
        apb(1'b0, ADDR_STATUS, 32'h0, 4'h0);
        chk(r, 32'h3);
        clkMode = 1'b0;
        wr(ADDR_CLKMODE, 8'h00);
        probe(4);
        $display("clock test done");
        for (int i = 0; i < 2; i++) begin
            wr(i == 0 ? ADDR_SERMODE : ADDR_SERCLK, 8'h81);
            repeat (3) @(posedge ref_clk);
            chk({31'h0, serialPortsFree}, 32'h0);
            wr(i == 0 ? ADDR_SERMODE : ADDR_SERCLK, 8'h00);
            repeat (3) @(posedge ref_clk);
            chk({31'h0, serialPortsFree}, 32'h1);
        end
        apb(1'b0, 8'h50, 32'h0, 4'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        apb(1'b1, 8'h54, 32'hFF, 4'hF);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, DIRA[1], {24'h0, ~dirS[1]}, 4'hE);
        probe(1);
        $display("refusal test done");
        test_done();
    end
endmodule : mpg_gpio_tb_top
